// ===== cbt_params.svh
// constants for the branch, timing and clock-select block
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define CBT_ADDR_CLK_SEL 8'h80
`define CBT_ADDR_STATUS 8'h84
`define CBT_CLK_SEL_RESET 8'h00
`define CBT_CLK_SEL_MASK 8'h1F

// ----------------------------------------
// field positions
// ----------------------------------------
`define CBT_BIT_HALT 4
`define CBT_BIT_SUB 3
`define CBT_BIT_DIV_EN 2

// ----------------------------------------
// machine cycle timing
// ----------------------------------------
`define CBT_PHASES 4'hC
`define CBT_PH_LAST 4'hB
`define CBT_PH_S1P1 4'h0
`define CBT_PH_S1P2 4'h1
`define CBT_PH_S4P1 4'h6
`define CBT_PH_S4P2 4'h7

// ----------------------------------------
// opcodes
// ----------------------------------------
`define CBT_OP_LONG_CALL 8'h12
`define CBT_OP_RET 8'h22
`define CBT_OP_INTERRUPT_RETURN 8'h32
`define CBT_OP_JZ 8'h60
`define CBT_OP_JNZ 8'h70
`define CBT_OP_DECREMENT_JUMP_NONZERO_DIR 8'hD5
`define CBT_OP_COMPARE_JUMP_UNEQUAL_AIMM 8'hB4
`define CBT_OP_COMPARE_JUMP_UNEQUAL_ADIR 8'hB5
`define CBT_ABSOLUTE_CALL_LOW 5'h11

`endif

// ===== cbt_pkg.sv
// types shared by the branch, timing and clock-select block
package cbt_pkg;

    typedef enum logic [3:0] {
        CBT_OTHER,
        CBT_LONG_CALL,
        CBT_ABSOLUTE_CALL,
        CBT_RET,
        CBT_INTERRUPT_RETURN,
        CBT_JZ,
        CBT_JNZ,
        CBT_DECREMENT_JUMP_NONZERO,
        CBT_COMPARE_JUMP_UNEQUAL
    } cbt_iclass_e;

    typedef struct packed {
        cbt_iclass_e cls;
        logic [1:0] len;
        logic two_cyc;
    } cbt_instr_s;

    typedef struct packed {
        logic [2:0] rsvd;
        logic halt;
        logic sub;
        logic [2:0] div;
    } cbt_clksel_s;

endpackage

// ===== cbt_core.sv
// control-transfer execution, machine-cycle sequencer and clock selector
`timescale 1ns/100ps
`include "cbt_params.svh"

module cbt_core
    import cbt_pkg::*;
#(
    parameter int STACK_DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sub_osc_in_i,
    output logic main_osc_halt_o,
    output logic [15:0] prog_addr_o,
    output logic prog_rd_o,
    input wire logic [7:0] prog_data_i,
    input wire logic [7:0] acc_i,
    output logic [7:0] data_addr_o,
    output logic data_reg_o,
    output logic data_ind_o,
    input wire logic [7:0] data_i,
    output logic data_we_o,
    output logic [7:0] data_wdata_o,
    output logic carry_o,
    output logic carry_we_o,
    input wire logic irq_active_i,
    output logic irq_done_o,
    output logic [15:0] pc_o,
    output logic [2:0] state_o,
    output logic phase2_o,
    output logic exec_done_o
);

    localparam int SPW = $clog2(STACK_DEPTH);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    cbt_clksel_s clk_sel_reg;
    cbt_clksel_s clk_eff_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic sub_meta_reg;
    logic sub_sync_reg;
    logic sub_prev_reg;
    logic sub_edge;
    logic [3:0] div_cnt_reg;
    logic [3:0] ratio_m1;
    logic [4:0] ratio_full;
    logic main_running;
    logic sys_tick;
    logic [3:0] phase_reg;
    logic cyc_reg;
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [7:0] op_reg;
    logic [7:0] b1_reg;
    logic [7:0] b2_reg;
    cbt_instr_s ins_reg;
    cbt_instr_s dec;
    logic fetch_slot;
    logic [1:0] slot_idx;
    logic exec;
    logic [15:0] stack_mem [STACK_DEPTH];
    logic [SPW-1:0] sp_reg;
    logic [7:0] first_op;
    logic [7:0] second_op;
    logic [7:0] rel;
    logic [7:0] dec_val;
    logic take_rel;
    logic [15:0] rel_target;
    logic wb_req;

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_sel_reg <= `CBT_CLK_SEL_RESET;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `CBT_ADDR_CLK_SEL) begin
            // reserved bits never store
            clk_sel_reg <= wb_dat_i[7:0] & `CBT_CLK_SEL_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `CBT_ADDR_CLK_SEL: rdata_reg <= {24'h00_0000, clk_sel_reg};
                `CBT_ADDR_STATUS: rdata_reg <= {pc_reg, 8'h00, clk_eff_reg[4:0],
                    state_o};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // system clock generation
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_meta_reg <= 1'b0;
            sub_sync_reg <= 1'b0;
            sub_prev_reg <= 1'b0;
        end else begin
            sub_meta_reg <= sub_osc_in_i;
            sub_sync_reg <= sub_meta_reg;
            sub_prev_reg <= sub_sync_reg;
        end
    end

    assign sub_edge = sub_sync_reg && !sub_prev_reg;
    assign main_osc_halt_o = clk_sel_reg.halt;

    // ratio minus one: 0, or 2**(low+1)-1
    assign ratio_full = (5'h02 << clk_eff_reg.div[1:0]) - 5'h01;
    assign ratio_m1 = clk_eff_reg.div[`CBT_BIT_DIV_EN] ? ratio_full[3:0] : 4'h0;
    assign main_running = !clk_eff_reg.sub && !clk_sel_reg.halt;
    assign sys_tick = clk_eff_reg.sub ? sub_edge : (main_running && div_cnt_reg == ratio_m1);

    // new selection is taken only at the end of a full period, so no
    // short pulse reaches the sequencer; a stalled main clock switches at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_eff_reg <= `CBT_CLK_SEL_RESET;
            div_cnt_reg <= 4'h0;
        end else if (sys_tick || !(clk_eff_reg.sub || main_running)) begin
            clk_eff_reg <= clk_sel_reg;
            div_cnt_reg <= 4'h0;
        end else if (main_running) begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
        end
    end

    // ----------------------------------------
    // machine cycle sequencer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= `CBT_PH_S1P1;
        end else if (sys_tick) begin
            phase_reg <= (phase_reg == `CBT_PH_LAST) ? `CBT_PH_S1P1 : phase_reg + 4'h1;
        end
    end

    assign state_o = 3'(phase_reg[3:1]) + 3'h1;
    assign phase2_o = phase_reg[0];
    // fetch issued in S1 and S4 of every cycle, needed or not
    assign prog_rd_o = (phase_reg[3:1] == 3'h0) || (phase_reg[3:1] == 3'h3);
    assign prog_addr_o = pc_reg;
    assign pc_o = pc_reg;

    assign fetch_slot = sys_tick && (phase_reg == `CBT_PH_S1P2 || phase_reg == `CBT_PH_S4P2);
    assign slot_idx = {cyc_reg, phase_reg == `CBT_PH_S4P2};
    assign exec = sys_tick && phase_reg == `CBT_PH_LAST && cyc_reg == ins_reg.two_cyc;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_reg <= 1'b0;
        end else if (sys_tick && phase_reg == `CBT_PH_LAST) begin
            cyc_reg <= exec ? 1'b0 : 1'b1;
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic cbt_instr_s decode(input logic [7:0] op);
        cbt_instr_s d;
        d = '{cls: CBT_OTHER, len: 2'h1, two_cyc: 1'b0};
        if (op == `CBT_OP_LONG_CALL) begin
            d = '{cls: CBT_LONG_CALL, len: 2'h3, two_cyc: 1'b1};
        end else if (op[4:0] == `CBT_ABSOLUTE_CALL_LOW) begin
            d = '{cls: CBT_ABSOLUTE_CALL, len: 2'h2, two_cyc: 1'b1};
        end else if (op == `CBT_OP_RET) begin
            d = '{cls: CBT_RET, len: 2'h1, two_cyc: 1'b1};
        end else if (op == `CBT_OP_INTERRUPT_RETURN) begin
            d = '{cls: CBT_INTERRUPT_RETURN, len: 2'h1, two_cyc: 1'b1};
        end else if (op == `CBT_OP_JZ) begin
            d = '{cls: CBT_JZ, len: 2'h2, two_cyc: 1'b1};
        end else if (op == `CBT_OP_JNZ) begin
            d = '{cls: CBT_JNZ, len: 2'h2, two_cyc: 1'b1};
        end else if (op == `CBT_OP_DECREMENT_JUMP_NONZERO_DIR) begin
            d = '{cls: CBT_DECREMENT_JUMP_NONZERO, len: 2'h3, two_cyc: 1'b1};
        end else if (op[7:3] == 5'h1B) begin
            d = '{cls: CBT_DECREMENT_JUMP_NONZERO, len: 2'h2, two_cyc: 1'b1};
        end else if (op[7:2] == 6'h2D || op[7:3] == 5'h17) begin
            d = '{cls: CBT_COMPARE_JUMP_UNEQUAL, len: 2'h3, two_cyc: 1'b1};
        end
        return d;
    endfunction

    assign dec = decode(prog_data_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_reg <= 8'h00;
            ins_reg <= '{cls: CBT_OTHER, len: 2'h1, two_cyc: 1'b0};
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
        end else if (fetch_slot) begin
            if (slot_idx == 2'h0) begin
                op_reg <= prog_data_i;
                ins_reg <= dec;
            end else if (slot_idx == 2'h1 && ins_reg.len > 2'h1) begin
                b1_reg <= prog_data_i;
            end else if (slot_idx == 2'h2 && ins_reg.len > 2'h2) begin
                b2_reg <= prog_data_i;
            end
        end
    end

    // ----------------------------------------
    // operand routing
    // ----------------------------------------
    assign data_ind_o = ins_reg.cls == CBT_COMPARE_JUMP_UNEQUAL && op_reg[7:1] == 7'h5B;
    assign data_reg_o = op_reg[3] && (ins_reg.cls == CBT_DECREMENT_JUMP_NONZERO || ins_reg.cls == CBT_COMPARE_JUMP_UNEQUAL);
    always_comb begin
        if (op_reg == `CBT_OP_DECREMENT_JUMP_NONZERO_DIR || op_reg == `CBT_OP_COMPARE_JUMP_UNEQUAL_ADIR) begin
            data_addr_o = b1_reg;
        end else if (data_ind_o) begin
            data_addr_o = {7'h00, op_reg[0]};
        end else begin
            data_addr_o = {5'h00, op_reg[2:0]};
        end
    end

    always_comb begin
        first_op = data_i;
        second_op = b1_reg;
        if (op_reg == `CBT_OP_COMPARE_JUMP_UNEQUAL_AIMM) begin
            first_op = acc_i;
        end else if (op_reg == `CBT_OP_COMPARE_JUMP_UNEQUAL_ADIR) begin
            first_op = acc_i;
            second_op = data_i;
        end
    end

    assign dec_val = data_i - 8'h01;
    assign rel = (ins_reg.len == 2'h3) ? b2_reg : b1_reg;
    // pc already points past the jump here
    assign rel_target = pc_reg + {{8{rel[7]}}, rel};

    always_comb begin
        case (ins_reg.cls)
            CBT_JZ: take_rel = acc_i == 8'h00;
            CBT_JNZ: take_rel = acc_i != 8'h00;
            CBT_DECREMENT_JUMP_NONZERO: take_rel = dec_val != 8'h00;
            CBT_COMPARE_JUMP_UNEQUAL: take_rel = first_op != second_op;
            default: take_rel = 1'b0;
        endcase
    end

    // ----------------------------------------
    // program counter and return stack
    // ----------------------------------------
    always_comb begin
        pc_next = pc_reg;
        if (exec) begin
            case (ins_reg.cls)
                CBT_LONG_CALL: pc_next = {b1_reg, b2_reg};
                CBT_ABSOLUTE_CALL: pc_next = {pc_reg[15:11], op_reg[7:5], b1_reg};
                CBT_RET, CBT_INTERRUPT_RETURN: pc_next = stack_mem[SPW'(sp_reg - 1'b1)];
                default: pc_next = take_rel ? rel_target : pc_reg;
            endcase
        end else if (fetch_slot && (slot_idx == 2'h0 || slot_idx < ins_reg.len)) begin
            pc_next = pc_reg + 16'h0001;
        end
        // otherwise the extra fetch is dropped and pc holds
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_reg <= 16'h0000;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // a small private stack; overflow wraps, oldest entry is lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_reg <= '0;
        end else if (exec && (ins_reg.cls == CBT_LONG_CALL || ins_reg.cls == CBT_ABSOLUTE_CALL)) begin
            stack_mem[sp_reg] <= pc_reg;
            sp_reg <= SPW'(sp_reg + 1'b1);
        end else if (exec && (ins_reg.cls == CBT_RET || ins_reg.cls == CBT_INTERRUPT_RETURN)) begin
            sp_reg <= SPW'(sp_reg - 1'b1);
        end
    end

    // ----------------------------------------
    // side effects
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_o <= 1'b0;
            carry_we_o <= 1'b0;
            data_we_o <= 1'b0;
            data_wdata_o <= 8'h00;
            irq_done_o <= 1'b0;
            exec_done_o <= 1'b0;
        end else begin
            carry_we_o <= exec && ins_reg.cls == CBT_COMPARE_JUMP_UNEQUAL;
            if (exec && ins_reg.cls == CBT_COMPARE_JUMP_UNEQUAL) begin
                carry_o <= first_op < second_op;
            end
            data_we_o <= exec && ins_reg.cls == CBT_DECREMENT_JUMP_NONZERO;
            if (exec && ins_reg.cls == CBT_DECREMENT_JUMP_NONZERO) begin
                data_wdata_o <= dec_val;
            end
            irq_done_o <= exec && ins_reg.cls == CBT_INTERRUPT_RETURN && irq_active_i;
            exec_done_o <= exec;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [4:0] gap_reg;
    logic prev_main_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_reg <= 5'h00;
            prev_main_reg <= 1'b0;
        end else begin
            gap_reg <= sys_tick ? 5'h00 : gap_reg + 5'h01;
            if (sys_tick) begin
                prev_main_reg <= !clk_eff_reg.sub;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_long_call_target: assert property (exec && ins_reg.cls == CBT_LONG_CALL |=>
        pc_reg == {$past(b1_reg), $past(b2_reg)}) else $error("long_call target wrong");
    chk_absolute_call_page: assert property (exec && ins_reg.cls == CBT_ABSOLUTE_CALL |=>
        pc_reg[15:11] == $past(pc_reg[15:11])) else $error("absolute_call left 2K block");
    chk_ret_push: assert property (exec && ins_reg.cls == CBT_LONG_CALL |=>
        stack_mem[SPW'(sp_reg - 1'b1)] == $past(pc_reg)) else $error("return address wrong");
    chk_interrupt_return_notify: assert property (irq_done_o == $past(exec &&
        ins_reg.cls == CBT_INTERRUPT_RETURN && irq_active_i)) else $error("interrupt_return notify wrong");
    chk_rel_target: assert property (exec && ins_reg.cls == CBT_JZ && acc_i == 8'h00 |=>
        pc_reg == $past(rel_target)) else $error("relative target wrong");
    chk_jz_acc: assert property (exec && ins_reg.cls == CBT_JZ && acc_i != 8'h00 |=>
        $stable(pc_reg)) else $error("jump_if_acc_zero taken on nonzero");
    chk_decrement_jump_nonzero_dec: assert property (exec && ins_reg.cls == CBT_DECREMENT_JUMP_NONZERO |=>
        data_we_o && data_wdata_o == $past(data_i) - 8'h01) else $error("decrement wrong");
    chk_compare_jump_unequal_equal: assert property (exec && ins_reg.cls == CBT_COMPARE_JUMP_UNEQUAL &&
        first_op == second_op |=> $stable(pc_reg)) else $error("compare jump on equal");
    chk_compare_jump_unequal_carry: assert property (exec && ins_reg.cls == CBT_COMPARE_JUMP_UNEQUAL |=> carry_we_o &&
        carry_o == $past(first_op < second_op)) else $error("compare carry wrong");
    chk_six_states: assert property (sys_tick && phase_reg == `CBT_PH_LAST |=>
        phase_reg == `CBT_PH_S1P1 && state_o == 3'h1) else $error("cycle not six states");
    chk_fetch_discard: assert property (fetch_slot && slot_idx != 2'h0 &&
        slot_idx >= ins_reg.len && !exec |=> $stable(pc_reg)) else $error("extra fetch advanced pc");
    chk_period_full: assert property (sys_tick && !clk_eff_reg.sub && prev_main_reg |->
        gap_reg == {1'b0, ratio_m1}) else $error("system clock period wrong");
    chk_reserved_zero: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == `CBT_ADDR_CLK_SEL |-> wb_dat_o[7:5] == 3'h0) else $error("reserved bits set");
    chk_clksel_reset: assert property (disable iff (1'b0) $past(rst_i) |->
        clk_sel_reg == `CBT_CLK_SEL_RESET) else $error("clock select not reset");

    cov_long_call: cover property (exec && ins_reg.cls == CBT_LONG_CALL);
    cov_interrupt_return_active: cover property (exec && ins_reg.cls == CBT_INTERRUPT_RETURN && irq_active_i);
    cov_sub_clock: cover property (sys_tick && clk_eff_reg.sub);
    cov_compare_jump_unequal_carry: cover property (exec && ins_reg.cls == CBT_COMPARE_JUMP_UNEQUAL && first_op < second_op);

endmodule

// ===== cbt_prog_model.sv
// program memory and interrupt-in-service model facing the core
`timescale 1ns/100ps

module cbt_prog_model (
    input wire logic clk_i,
    input wire logic [15:0] prog_addr_i,
    input wire logic prog_rd_i,
    output logic [7:0] prog_data_o,
    input wire logic irq_raise_i,
    input wire logic irq_done_i,
    output logic irq_active_o
);
    logic [7:0] mem [0:65535];

    // outside a fetch the bus carries junk, never the last byte
    assign prog_data_o = prog_rd_i ? mem[prog_addr_i] : ~mem[prog_addr_i];

    initial begin
        irq_active_o = 1'b0;
        foreach (mem[i]) mem[i] = 8'h00;
    end

    always @(posedge clk_i) begin
        if (irq_raise_i) begin
            irq_active_o <= 1'b1;
        end else if (irq_done_i) begin
            irq_active_o <= 1'b0;
        end
    end
endmodule

// ===== cbt_core_tb_top.sv
// self-checking bench for the branch, timing and clock-select core
`timescale 1ns/100ps

module cbt_core_tb_top;
    import cbt_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, sub_osc_in_i, irq_raise, irq_active;
    logic [7:0] wb_adr_i, prog_data, acc_i, data_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, main_osc_halt_o, prog_rd_o, data_reg_o, data_ind_o, data_we_o;
    logic carry_o, carry_we_o, irq_done_o, phase2_o, exec_done_o;
    logic [15:0] prog_addr_o, pc_o;
    logic [7:0] data_addr_o, data_wdata_o;
    logic [2:0] state_o;
    logic [1:0] sub_div = 2'b00;
    typedef struct packed {
        logic [15:0] pc;
        logic cwe, cy, dwe, idone;
        logic [7:0] wd;
    } cbt_exp_s;
    cbt_exp_s exp_q[$];
    cbt_exp_s mon_e;
    int failures = 0;
    int compares = 0;

    always #2 clk_i = ~clk_i;
    // sub oscillator runs free at a quarter of the main clock
    always @(posedge clk_i) begin
        sub_div <= sub_div + 2'b01;
        sub_osc_in_i <= sub_div[1];
    end

    cbt_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sub_osc_in_i(sub_osc_in_i),
        .main_osc_halt_o(main_osc_halt_o), .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o),
        .prog_data_i(prog_data), .acc_i(acc_i), .data_addr_o(data_addr_o),
        .data_reg_o(data_reg_o), .data_ind_o(data_ind_o), .data_i(data_i),
        .data_we_o(data_we_o), .data_wdata_o(data_wdata_o), .carry_o(carry_o),
        .carry_we_o(carry_we_o), .irq_active_i(irq_active), .irq_done_o(irq_done_o),
        .pc_o(pc_o), .state_o(state_o), .phase2_o(phase2_o), .exec_done_o(exec_done_o));

    cbt_prog_model pm (.clk_i(clk_i), .prog_addr_i(prog_addr_o), .prog_rd_i(prog_rd_o),
        .prog_data_o(prog_data), .irq_raise_i(irq_raise), .irq_done_i(irq_done_o),
        .irq_active_o(irq_active));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] ad, input logic [7:0] wd,
                      input logic [3:0] sel, output logic [31:0] rd);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= ad;
        wb_sel_i <= sel;
        wb_dat_i <= {24'($urandom()), wd};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        rd = wb_dat_o;
        if (k >= 50) chk("wb_ack", 32'h0000_0001, 32'(wb_ack_o));
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic put(input logic [15:0] ad, input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) pm.mem[ad + 16'(i)] = v[31 - 8 * i -: 8];
    endtask

    function automatic logic [15:0] sx(input logic [7:0] r);
        return {{8{r[7]}}, r};
    endfunction

    // walks the image the way the core should and queues each outcome
    task automatic ref_run(input logic [7:0] a, input logic [7:0] d, input logic irq);
        logic [15:0] pc, nx;
        logic [7:0] op, b1, b2;
        logic [15:0] stk[$];
        cbt_exp_s e;
        pc = 16'h0000;
        repeat (10) begin
            op = pm.mem[pc];
            b1 = pm.mem[pc + 16'h0001];
            b2 = pm.mem[pc + 16'h0002];
            e = '0;
            nx = pc + 16'h0001;
            if (op == 8'h12) begin
                stk.push_back(pc + 16'h0003);
                nx = {b1, b2};
            end else if (op[4:0] == 5'h11) begin
                stk.push_back(pc + 16'h0002);
                nx = {stk[$][15:11], op[7:5], b1};
            end else if (op == 8'h22 || op == 8'h32) begin
                nx = stk.pop_back();
                e.idone = irq && (op == 8'h32);
                irq = irq && (op != 8'h32);
            end else if (op == 8'h60 || op == 8'h70) begin
                nx = pc + 16'h0002;
                if ((a == 8'h00) == (op == 8'h60)) nx = nx + sx(b1);
            end else if (op == 8'hD5) begin
                e.dwe = 1'b1;
                e.wd = d - 8'h01;
                nx = pc + 16'h0003;
                if (e.wd != 8'h00) nx = nx + sx(b2);
            end else if (op == 8'hB4) begin
                e.cwe = 1'b1;
                e.cy = a < b1;
                nx = pc + 16'h0003;
                if (a != b1) nx = nx + sx(b2);
            end
            e.pc = nx;
            exp_q.push_back(e);
            pc = nx;
        end
    endtask

    task automatic do_reset(input logic irq);
        rst_i <= 1'b1;
        irq_raise <= irq;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        irq_raise <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_q();
        int k;
        k = 0;
        while (exp_q.size() > 0 && k < 4000) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 4000) chk("run_complete", 32'h0000_0000, 32'(exp_q.size()));
    endtask

    // clocks between two completions, and how many of them fetched
    task automatic measure(output int n, output int rd);
        int k;
        k = 0;
        n = 0;
        rd = 0;
        while (exec_done_o !== 1'b1 && k < 1000) begin
            @(posedge clk_i);
            k++;
        end
        do begin
            @(posedge clk_i);
            n++;
            if (prog_rd_o === 1'b1) rd++;
        end while (exec_done_o !== 1'b1 && n < 1000);
    endtask

    // ----------------------------------------
    // result monitor
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i === 1'b0 && exec_done_o === 1'b1 && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            chk("pc", 32'(mon_e.pc), 32'(pc_o));
            chk("state", 32'h0000_0001, 32'(state_o));
            chk("carry_we", 32'(mon_e.cwe), 32'(carry_we_o));
            if (mon_e.cwe) chk("carry", 32'(mon_e.cy), 32'(carry_o));
            chk("data_we", 32'(mon_e.dwe), 32'(data_we_o));
            if (mon_e.dwe) chk("wdata", 32'(mon_e.wd), 32'(data_wdata_o));
            if (mon_e.dwe) chk("data_addr", 32'h0000_0030, 32'(data_addr_o));
            if (mon_e.dwe) chk("data_reg", 32'h0000_0000, 32'(data_reg_o));
            if (mon_e.cwe) chk("data_ind", 32'h0000_0000, 32'(data_ind_o));
            chk("phase2", 32'h0000_0000, 32'(phase2_o));
            chk("irq_done", 32'(mon_e.idone), 32'(irq_done_o));
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("watchdog expired");
        close_out();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n, rd;
        logic [31:0] r;
        // clock choices a program may pick for its counter rates
        logic [7:0] cfg [7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h18};
        int ln [7] = '{12, 24, 48, 96, 192, 48, 48};
        {wb_cyc_i, wb_stb_i, wb_we_i, sub_osc_in_i, irq_raise} = 5'b00000;
        {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        acc_i = 8'h00;
        data_i = 8'h01;
        n = $urandom(61459);
        put(16'h0000, 32'h1212_3400, 3);
        put(16'h1234, 32'h6005_7003, 4);
        put(16'h123B, 32'h7000_D530, 4);
        put(16'h123F, 32'h00B4_0510, 4);
        put(16'h1253, 32'hB400_1071, 4);
        put(16'h1257, 32'hFE32_0000, 2);
        put(16'h13FE, 32'h2200_0000, 1);
        ref_run(8'h00, 8'h01, 1'b1);
        do_reset(1'b1);
        wait_q();
        $display("branch run with zero accumulator done");
        wb(1'b0, 8'h80, 8'h00, 4'h1, r);
        chk("sel_reset", 32'h0000_0000, r);
        wb(1'b1, 8'h80, 8'hFF, 4'h1, r);
        wb(1'b0, 8'h80, 8'h00, 4'h1, r);
        chk("sel_rsvd", 32'h0000_001F, r);
        chk("halt_set", 32'h0000_0001, 32'(main_osc_halt_o));
        wb(1'b1, 8'h80, 8'h00, 4'h0, r);
        wb(1'b1, 8'h10, 8'hAA, 4'h1, r);
        wb(1'b0, 8'h10, 8'h00, 4'h1, r);
        chk("unmapped", 32'h0000_0000, r);
        wb(1'b0, 8'h80, 8'h00, 4'h1, r);
        chk("sel_kept", 32'h0000_001F, r);
        wb(1'b1, 8'h80, 8'h00, 4'h1, r);
        $display("register test done");
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, 8'h80, cfg[i], 4'h1, r);
            measure(n, rd);
            measure(n, rd);
            chk("cycle_len", ln[i], n);
            chk("fetch_len", n, rd * 3);
            chk("halt", 32'(cfg[i][4]), 32'(main_osc_halt_o));
            wb(1'b0, 8'h84, 8'h00, 4'h1, r);
            chk("status_sel", 32'(cfg[i][4:0]), 32'(r[7:3]));
        end
        wb(1'b1, 8'h80, 8'h00, 4'h1, r);
        $display("clock select test done");
        acc_i <= 8'(1 + $urandom % 255);
        data_i <= 8'(2 + $urandom % 254);
        @(posedge clk_i);
        // queue only after reset has cleared the core, so a stray completion cannot pop it
        do_reset(1'b0);
        ref_run(acc_i, data_i, 1'b0);
        wait_q();
        $display("branch run with random operands done");
        close_out();
    end
endmodule
